//--- event_flag_defines.svh
// Register offsets, field sizes and reset values for the event flag block
`ifndef EVENT_FLAG_DEFINES_SVH
`define EVENT_FLAG_DEFINES_SVH

`define EFI_NUM_FLAGS 11
`define EFI_LO_FLAGS 8
`define EFI_HI_FLAGS 3
`define EFI_ADDR_W 8
`define EFI_DATA_W 8

`define EFI_OFS_ENABLE_LO 8'h03
`define EFI_OFS_ENABLE_HI 8'h04
`define EFI_OFS_FLAG_LO 8'h05
`define EFI_OFS_FLAG_HI 8'h06
`define EFI_OFS_ROUTE_A 8'h07
`define EFI_OFS_ROUTE_B 8'h08

`define EFI_ENABLE_RESET 11'h000
`define EFI_ROUTE_RESET 11'h000
`define EFI_FLAG_RESET 11'h000
`define EFI_BYTE_ZERO 8'h00

`endif

//--- event_flag_pkg.sv
// Types shared by the event flag modules
package event_flag_pkg;
  `include "event_flag_defines.svh"

  typedef logic [`EFI_NUM_FLAGS-1:0] flag_vec_t;
  typedef logic [`EFI_DATA_W-1:0] reg_byte_t;
  typedef logic [`EFI_ADDR_W-1:0] reg_addr_t;
endpackage : event_flag_pkg

//--- flag_bank_if.sv
// Carrier between the register logic and the flag bank
`timescale 1ns/10ps
interface flag_bank_if;
  import event_flag_pkg::*;
  flag_vec_t enable;
  flag_vec_t clear_w1c;
  logic clear_all;
  flag_vec_t flag_read;
  flag_vec_t flag_latched;

  modport ctrl (
    output enable,
    output clear_w1c,
    output clear_all,
    input flag_read,
    input flag_latched
  );
  modport bank (
    input enable,
    input clear_w1c,
    input clear_all,
    output flag_read,
    output flag_latched
  );
endinterface : flag_bank_if

//--- flag_bank.sv
// Synchronisers, edge detection and latches for all event flags
`timescale 1ns/10ps
`include "event_flag_defines.svh"
module flag_bank
  import event_flag_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire flag_vec_t event_source_in,
  flag_bank_if.bank bank
);
  flag_vec_t sync1_reg;
  flag_vec_t sync2_reg;
  flag_vec_t prev_reg;
  flag_vec_t latched_reg;
  flag_vec_t rise;
  flag_vec_t set_evt;

  // Sources come from other clock domains such as the PLL
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync1_reg <= `EFI_FLAG_RESET;
      sync2_reg <= `EFI_FLAG_RESET;
      prev_reg <= `EFI_FLAG_RESET;
    end else begin
      sync1_reg <= event_source_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign set_evt = rise & bank.enable;

  // Set beats a same-cycle write-one clear so no edge is lost
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || bank.clear_all) begin
      latched_reg <= `EFI_FLAG_RESET;
    end else begin
      latched_reg <= set_evt | (latched_reg & ~bank.clear_w1c);
    end
  end

  assign bank.flag_latched = latched_reg;
  // Disabled flags show the live synchronised level
  assign bank.flag_read = (latched_reg & bank.enable) | (sync2_reg & ~bank.enable);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_edge_latch: assert property ((set_evt != 0) && !bank.clear_all |=>
      (bank.flag_latched & $past(set_evt)) == $past(set_evt))
    else $error("enabled rising edge did not latch its flag");
  a_live_read: assert property ((bank.flag_read & ~bank.enable) == (sync2_reg & ~bank.enable))
    else $error("disabled flag does not read its live source");
  a_w1c_clear: assert property ((bank.clear_w1c & ~set_evt) != 0 |=>
      (bank.flag_latched & $past(bank.clear_w1c & ~set_evt)) == 0)
    else $error("write one did not clear latched flag");
  a_reset_clear: assert property (bank.clear_all |=> bank.flag_latched == 0)
    else $error("software reset left a flag latched");
endmodule : flag_bank

//--- event_flag_irq.sv
// Event flag registers and open-drain interrupt request pins
//
// Functional notes
// - Every flag watches one status source and owns one interrupt enable bit.
// - Enabled flag latches on source rising edge and then requests an interrupt.
// - Disabled flag reads the live source level and never requests.
// - Writing one to a latched flag bit clears it.
// - Hardware or software reset clears every latched flag.
// - Both request pins work alike; any enabled latched flag can drive its pin.
// - Route bits at 0x07 and 0x08 pick pin: 0 first, 1 second.
// - Writing a flag bit also releases a source that is held internally.
// - Eleven flags at 0x05 and 0x06, their enables at 0x03 and 0x04.
// - Request pins are open-drain and active low, pulling low only.
`timescale 1ns/10ps
`include "event_flag_defines.svh"
module event_flag_irq
  import event_flag_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic soft_rst_in,
  input wire reg_addr_t reg_addr_in,
  input wire reg_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output reg_byte_t reg_rdata_out,
  output logic reg_rvalid_out,
  input wire flag_vec_t event_source_in,
  output flag_vec_t source_release_out,
  input wire logic request_pin_first_in,
  output logic request_pin_first_out,
  output logic request_pin_first_oe_out,
  input wire logic request_pin_second_in,
  output logic request_pin_second_out,
  output logic request_pin_second_oe_out
);
  flag_bank_if fb ();

  flag_vec_t enable_reg;
  flag_vec_t route_reg;
  flag_vec_t release_reg;
  reg_byte_t rdata_reg;
  logic rvalid_reg;
  logic oe_first_reg;
  logic oe_second_reg;
  flag_vec_t w1c_mask;
  flag_vec_t active;
  reg_byte_t rdata_next;
  logic wr_flag_lo;
  logic wr_flag_hi;
  logic [1:0] line_first_sync_reg;
  logic [1:0] line_second_sync_reg;

  flag_bank u_flag_bank (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .event_source_in(event_source_in),
    .bank(fb.bank)
  );

  assign wr_flag_lo = reg_wr_in && (reg_addr_in == `EFI_OFS_FLAG_LO);
  assign wr_flag_hi = reg_wr_in && (reg_addr_in == `EFI_OFS_FLAG_HI);

  always_comb begin
    w1c_mask = `EFI_FLAG_RESET;
    if (wr_flag_lo) begin
      w1c_mask[`EFI_LO_FLAGS-1:0] = reg_wdata_in;
    end
    if (wr_flag_hi) begin
      w1c_mask[`EFI_NUM_FLAGS-1:`EFI_LO_FLAGS] = reg_wdata_in[`EFI_HI_FLAGS-1:0];
    end
  end

  assign fb.enable = enable_reg;
  assign fb.clear_w1c = w1c_mask;
  assign fb.clear_all = soft_rst_in;

  // Enable registers, one bit per flag
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      enable_reg <= `EFI_ENABLE_RESET;
    end else if (reg_wr_in && reg_addr_in == `EFI_OFS_ENABLE_LO) begin
      enable_reg[`EFI_LO_FLAGS-1:0] <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == `EFI_OFS_ENABLE_HI) begin
      enable_reg[`EFI_NUM_FLAGS-1:`EFI_LO_FLAGS] <= reg_wdata_in[`EFI_HI_FLAGS-1:0];
    end
  end

  // Route registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      route_reg <= `EFI_ROUTE_RESET;
    end else if (reg_wr_in && reg_addr_in == `EFI_OFS_ROUTE_A) begin
      route_reg[`EFI_LO_FLAGS-1:0] <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == `EFI_OFS_ROUTE_B) begin
      route_reg[`EFI_NUM_FLAGS-1:`EFI_LO_FLAGS] <= reg_wdata_in[`EFI_HI_FLAGS-1:0];
    end
  end

  // Release pulse lets internally held sources drop with the flag
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      release_reg <= `EFI_FLAG_RESET;
    end else begin
      release_reg <= w1c_mask;
    end
  end
  assign source_release_out = release_reg;

  always_comb begin
    rdata_next = `EFI_BYTE_ZERO;
    case (reg_addr_in)
      `EFI_OFS_ENABLE_LO: rdata_next = enable_reg[`EFI_LO_FLAGS-1:0];
      `EFI_OFS_ENABLE_HI: rdata_next[`EFI_HI_FLAGS-1:0] =
          enable_reg[`EFI_NUM_FLAGS-1:`EFI_LO_FLAGS];
      `EFI_OFS_FLAG_LO: rdata_next = fb.flag_read[`EFI_LO_FLAGS-1:0];
      `EFI_OFS_FLAG_HI: rdata_next[`EFI_HI_FLAGS-1:0] =
          fb.flag_read[`EFI_NUM_FLAGS-1:`EFI_LO_FLAGS];
      `EFI_OFS_ROUTE_A: rdata_next = route_reg[`EFI_LO_FLAGS-1:0];
      `EFI_OFS_ROUTE_B: rdata_next[`EFI_HI_FLAGS-1:0] =
          route_reg[`EFI_NUM_FLAGS-1:`EFI_LO_FLAGS];
      default: rdata_next = `EFI_BYTE_ZERO;
    endcase
  end

  // Read data is registered; unmapped addresses read as zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_reg <= `EFI_BYTE_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_reg <= rdata_next;
      end
    end
  end
  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;

  // Only enabled, latched flags may request
  assign active = fb.flag_latched & enable_reg;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      oe_first_reg <= 1'b0;
      oe_second_reg <= 1'b0;
    end else begin
      oe_first_reg <= |(active & ~route_reg);
      oe_second_reg <= |(active & route_reg);
    end
  end

  // Request lines are shared wired-OR nets from outside, so two flops first;
  // the level only tells that someone pulls, never which device
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      line_first_sync_reg <= 2'h3;
      line_second_sync_reg <= 2'h3;
    end else begin
      line_first_sync_reg <= {line_first_sync_reg[0], request_pin_first_in};
      line_second_sync_reg <= {line_second_sync_reg[0], request_pin_second_in};
    end
  end

  // Open drain: the data line is always low, only the enable moves
  assign request_pin_first_out = 1'b0;
  assign request_pin_second_out = 1'b0;
  assign request_pin_first_oe_out = oe_first_reg;
  assign request_pin_second_oe_out = oe_second_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_first_drive: assert property (##1 request_pin_first_oe_out ==
      $past(|(fb.flag_latched & enable_reg & ~route_reg)))
    else $error("first request pin does not follow routed flags");
  a_second_route: assert property (##1 request_pin_second_oe_out ==
      $past(|(fb.flag_latched & enable_reg & route_reg)))
    else $error("second request pin does not follow routed flags");
  a_disabled_quiet: assert property (enable_reg == 0 ##1 enable_reg == 0 |->
      !request_pin_first_oe_out && !request_pin_second_oe_out)
    else $error("request pin driven with all flags disabled");
  a_open_drain: assert property (request_pin_first_oe_out |-> !request_pin_first_out)
    else $error("first request pin driven high");
  a_release_pulse: assert property (wr_flag_lo |=>
      source_release_out[`EFI_LO_FLAGS-1:0] == $past(reg_wdata_in))
    else $error("flag write did not release held source");
  a_read_answer: assert property (reg_rd_in && reg_addr_in == `EFI_OFS_FLAG_LO |=>
      reg_rvalid_out && reg_rdata_out == $past(fb.flag_read[`EFI_LO_FLAGS-1:0]))
    else $error("flag read returned wrong data");
  a_enable_write: assert property (reg_wr_in && reg_addr_in == `EFI_OFS_ENABLE_LO |=>
      enable_reg[`EFI_LO_FLAGS-1:0] == $past(reg_wdata_in))
    else $error("enable write not stored");
  a_both_pins: assert property (##1 (|(fb.flag_latched & enable_reg)) |=>
      request_pin_first_oe_out || request_pin_second_oe_out)
    else $error("active flag drives no request pin");
  a_route_write: assert property (reg_wr_in && reg_addr_in == `EFI_OFS_ROUTE_A |=>
      route_reg[`EFI_LO_FLAGS-1:0] == $past(reg_wdata_in))
    else $error("route write not stored");
  a_second_drain: assert property (request_pin_second_oe_out |->
      !request_pin_second_out)
    else $error("second request pin driven high");
  a_rvalid_pulse: assert property (##1 reg_rvalid_out == $past(reg_rd_in))
    else $error("read valid does not follow read strobe");
  a_high_bits_zero: assert property (reg_rd_in && reg_addr_in == `EFI_OFS_FLAG_HI |=>
      reg_rdata_out[`EFI_DATA_W-1:`EFI_HI_FLAGS] == '0)
    else $error("unused flag register bits read nonzero");
  a_unmapped_read: assert property (reg_rd_in && reg_addr_in > `EFI_OFS_ROUTE_B |=>
      reg_rdata_out == `EFI_BYTE_ZERO)
    else $error("unmapped address read nonzero");
  a_soft_clear: assert property (soft_rst_in |=> ##1
      !request_pin_first_oe_out && !request_pin_second_oe_out)
    else $error("request pin still driven after software reset");

  c_first_irq: cover property (!request_pin_first_oe_out ##1 request_pin_first_oe_out);
  c_second_irq: cover property (!request_pin_second_oe_out ##1 request_pin_second_oe_out);
  c_w1c_release: cover property (request_pin_first_oe_out && wr_flag_lo
      ##2 !request_pin_first_oe_out);
  c_soft_reset: cover property (request_pin_second_oe_out && soft_rst_in);
  c_line_seen_low: cover property (!line_first_sync_reg[1] || !line_second_sync_reg[1]);
endmodule : event_flag_irq

//--- irq_host_model.sv
// Host end of the two request lines, each with its pull-up resistor
`timescale 1ns/10ps
module irq_host_model (
  input wire logic first_out_in,
  input wire logic first_oe_in,
  input wire logic second_out_in,
  input wire logic second_oe_in,
  output logic first_level_out,
  output logic second_level_out
);
  // Pull-up wins once the device lets go, so an idle line reads high
  assign first_level_out = first_oe_in ? first_out_in : 1'b1;
  assign second_level_out = second_oe_in ? second_out_in : 1'b1;
endmodule : irq_host_model

//--- event_flag_irq_logic_test.sv
// Self-checking bench for the event flag and request pin logic
`timescale 1ns/10ps
module event_flag_irq_logic_test;
  import event_flag_pkg::*;
  typedef struct {int idx; logic en; logic rt; logic oe1; logic oe2;} row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic srst = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  reg_addr_t addr = 8'h00;
  reg_byte_t wdata = 8'h00;
  reg_byte_t rdata;
  flag_vec_t src = 11'h000;
  flag_vec_t rel;
  flag_vec_t f;
  flag_vec_t v;
  logic rvalid, p1_out, p1_oe, p2_out, p2_oe, p1_lvl, p2_lvl;
  int err_count = 0;
  int tests_run = 0;
  row_s rows[6] = '{'{0, 1, 0, 1, 0}, '{7, 1, 1, 0, 1}, '{8, 1, 0, 1, 0},
                    '{10, 1, 1, 0, 1}, '{3, 0, 0, 0, 0}, '{9, 0, 1, 0, 0}};
  always #2 clk = ~clk;
  event_flag_irq dut (.sys_clk_in(clk), .rst_in(rst), .soft_rst_in(srst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_en), .reg_rd_in(rd_en),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .event_source_in(src),
    .source_release_out(rel), .request_pin_first_in(p1_lvl),
    .request_pin_first_out(p1_out), .request_pin_first_oe_out(p1_oe),
    .request_pin_second_in(p2_lvl), .request_pin_second_out(p2_out),
    .request_pin_second_oe_out(p2_oe));
  irq_host_model host (.first_out_in(p1_out), .first_oe_in(p1_oe), .second_out_in(p2_out),
    .second_oe_in(p2_oe), .first_level_out(p1_lvl), .second_level_out(p2_lvl));
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // Release pulses appear only for flag register bits written with 1
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    check(rel, a == 8'h05 ? {3'h0, d} : a == 8'h06 ? {d[2:0], 8'h00} : 11'h000);
  endtask : wr
  task automatic rd(input reg_addr_t a, output reg_byte_t d);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    check(rvalid, 1'b1);
    d = rdata;
  endtask : rd
  task automatic wr11(input reg_addr_t a, input flag_vec_t x);
    wr(a, x[7:0]);
    wr(a + 8'h01, {5'h00, x[10:8]});
  endtask : wr11
  task automatic rdflags(output flag_vec_t x);
    reg_byte_t b0, b1;
    rd(8'h05, b0);
    rd(8'h06, b1);
    x = {b1[2:0], b0};
    check(b1[7:3], 5'h00);
  endtask : rdflags
  task automatic pulse(input flag_vec_t x);
    src = x;
    repeat (6) @(negedge clk);
    src = 11'h000;
    repeat (6) @(negedge clk);
  endtask : pulse
  initial begin
    #80000;
    err_count++;
    conclude();
  end
  initial begin
    reg_byte_t b;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    wr(8'h09, 8'hff);
    for (int a = 0; a < 10; a++) begin
      rd(a[7:0], b);
      check(b, 8'h00);
    end
    $display("test reset values done");
    foreach (rows[i]) begin
      v = 11'h001 << rows[i].idx;
      wr11(8'h03, rows[i].en ? v : 11'h000);
      wr11(8'h07, rows[i].rt ? v : 11'h000);
      rd(8'h07, b);
      check(b, rows[i].rt ? v[7:0] : 8'h00);
      rd(8'h08, b);
      check(b, rows[i].rt ? {5'h00, v[10:8]} : 8'h00);
      src = v;
      repeat (6) @(negedge clk);
      check({p1_oe, p2_oe}, {rows[i].oe1, rows[i].oe2});
      check({p1_lvl, p2_lvl, p1_out, p2_out}, {~rows[i].oe1, ~rows[i].oe2, 2'b00});
      rdflags(f);
      check(f, v);
      src = 11'h000;
      repeat (6) @(negedge clk);
      rdflags(f);
      check(f, rows[i].en ? v : 11'h000);
      wr11(8'h05, v);
      rdflags(f);
      check(f, 11'h000);
      check({p1_oe, p2_oe}, 2'b00);
    end
    $display("test routing rows done");
    wr11(8'h03, 11'h003);
    wr11(8'h07, 11'h000);
    pulse(11'h003);
    wr(8'h05, 8'h01);
    check({p1_oe, p2_oe}, 2'b10);
    wr(8'h05, 8'h02);
    @(negedge clk);
    check({p1_oe, p2_oe}, 2'b00);
    $display("test shared pin done");
    // Edge reaches the latch in the very cycle the clear write is taken
    src = 11'h001;
    @(negedge clk);
    wr(8'h05, 8'h01);
    src = 11'h000;
    rdflags(f);
    check(f, 11'h001);
    wr(8'h05, 8'h01);
    rdflags(f);
    check(f, 11'h000);
    $display("test set beats clear done");
    // Host service sequence: read, disable, reread, clear, re-enable
    wr11(8'h03, 11'h020);
    rd(8'h03, b);
    check(b, 8'h20);
    wr11(8'h07, 11'h020);
    pulse(11'h020);
    rdflags(f);
    check(f, 11'h020);
    wr11(8'h03, 11'h000);
    @(negedge clk);
    check({p1_oe, p2_oe}, 2'b00);
    rdflags(f);
    check(f, 11'h000);
    wr11(8'h05, 11'h020);
    wr11(8'h03, 11'h020);
    @(negedge clk);
    check({p1_oe, p2_oe}, 2'b00);
    $display("test service routine done");
    wr11(8'h03, 11'h100);
    wr11(8'h07, 11'h000);
    pulse(11'h100);
    check(p1_oe, 1'b1);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check(p1_oe, 1'b0);
    rdflags(f);
    check(f, 11'h000);
    rd(8'h04, b);
    check(b, 8'h01);
    pulse(11'h100);
    check(p1_oe, 1'b1);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check(p1_oe, 1'b0);
    rd(8'h04, b);
    check(b, 8'h00);
    $display("test resets done");
    conclude();
  end
endmodule : event_flag_irq_logic_test
